// file: rtl/sbsc_cycle_decode.v
// Cycle decoder, burst address logic and output register of a burst SRAM.
// Assumes synchronous inputs; output_drive_en_n acts asynchronously.
`timescale 1ns/1ns
`default_nettype none
`include "sbsc_defs.vh"
module sbsc_cycle_decode #(
    parameter ADDR_W = `SBSC_ADDR_W,
    parameter LANES = `SBSC_LANES,
    parameter LANE_W = `SBSC_LANE_W
) (
    input wire mclk,
    input wire rst_b,
    input wire select_pipelined_n,
    input wire depth_select_hi,
    input wire depth_select_lo_n,
    input wire sleep_request,
    input wire cpu_addr_strobe_n,
    input wire ctrl_addr_strobe_n,
    input wire burst_step_n,
    input wire global_write_n,
    input wire byte_write_gate_n,
    input wire [LANES-1:0] lane_write_sel_n,
    input wire output_drive_en_n,
    input wire mode,
    input wire [ADDR_W-1:0] addr,
    input wire [LANES*LANE_W-1:0] data_in,
    output reg [LANES*LANE_W-1:0] data_out,
    output reg [LANES*LANE_W-1:0] data_oe,
    output reg [`SBSC_OP_W-1:0] cycle_op,
    output reg powered_down
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rst_meta;
    reg rst_sync;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ----------------------------------------
    // Cycle decode
    // ----------------------------------------
    wire chip_on = !select_pipelined_n && depth_select_hi && !depth_select_lo_n;
    wire is_write = !global_write_n || (!byte_write_gate_n && !(&lane_write_sel_n));
    wire desel_a = select_pipelined_n && !ctrl_addr_strobe_n;
    wire desel_b = !select_pipelined_n && (!cpu_addr_strobe_n || !ctrl_addr_strobe_n)
        && (!depth_select_hi || depth_select_lo_n);
    wire start_cpu = chip_on && !cpu_addr_strobe_n;
    wire start_ctrl = chip_on && cpu_addr_strobe_n && !ctrl_addr_strobe_n;
    wire no_start = ctrl_addr_strobe_n && (cpu_addr_strobe_n || select_pipelined_n);

    reg [`SBSC_OP_W-1:0] next_op;
    reg next_wr;
    always @* begin
        next_op = `SBSC_OP_IDLE;
        next_wr = 1'b0;
        if (sleep_request) begin
            next_op = `SBSC_OP_SLEEP;
        end else if (desel_a || desel_b) begin
            next_op = `SBSC_OP_DESEL;
        end else if (start_cpu) begin
            next_op = `SBSC_OP_BEGIN;
            next_wr = 1'b0;
        end else if (start_ctrl) begin
            next_op = `SBSC_OP_BEGIN;
            next_wr = is_write;
        end else if (no_start && !burst_step_n) begin
            next_op = `SBSC_OP_NEXT;
            next_wr = is_write;
        end else if (no_start) begin
            next_op = `SBSC_OP_HOLD;
            next_wr = is_write;
        end
    end

    // ----------------------------------------
    // Burst address
    // ----------------------------------------
    reg [ADDR_W-1:0] base_addr;
    reg [1:0] burst_count;
    reg active;
    reg first_after_desel;
    wire [1:0] cur_low;
    wire [1:0] next_low;
    sbsc_burst_step u_cur (
        .base(base_addr[1:0]),
        .count(burst_count),
        .mode(mode),
        .addr_low(cur_low)
    );
    sbsc_burst_step u_next (
        .base(base_addr[1:0]),
        .count(burst_count + 2'h1),
        .mode(mode),
        .addr_low(next_low)
    );
    reg [ADDR_W-1:0] acc_addr;
    always @* begin
        acc_addr = {base_addr[ADDR_W-1:2], cur_low};
        if (next_op == `SBSC_OP_BEGIN) begin
            acc_addr = addr;
        end else if (next_op == `SBSC_OP_NEXT) begin
            acc_addr = {base_addr[ADDR_W-1:2], next_low};
        end
    end
    wire do_access = active && ((next_op == `SBSC_OP_NEXT) || (next_op == `SBSC_OP_HOLD))
        || (next_op == `SBSC_OP_BEGIN);
    wire do_write = do_access && next_wr;
    wire [LANES-1:0] lane_we = !do_write ? {LANES{1'b0}} :
        (!global_write_n ? {LANES{1'b1}} : ~lane_write_sel_n);

    wire [LANES*LANE_W-1:0] mem_rdata;
    sbsc_lane_mem #(
        .ADDR_W(ADDR_W),
        .LANES(LANES),
        .LANE_W(LANE_W)
    ) u_mem (
        .mclk(mclk),
        .addr(acc_addr),
        .lane_we(lane_we),
        .wdata(data_in),
        .rdata(mem_rdata)
    );

    // ----------------------------------------
    // State and output register
    // ----------------------------------------
    reg read_valid;
    always @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            base_addr <= {ADDR_W{1'b0}};
            burst_count <= 2'h0;
            active <= 1'b0;
            first_after_desel <= 1'b1;
            read_valid <= 1'b0;
            data_out <= {LANES*LANE_W{1'b0}};
            cycle_op <= `SBSC_OP_IDLE;
            powered_down <= 1'b1;
        end else begin
            cycle_op <= next_op;
            powered_down <= (next_op == `SBSC_OP_SLEEP) || (next_op == `SBSC_OP_DESEL)
                || (!active && next_op != `SBSC_OP_BEGIN);
            if (next_op == `SBSC_OP_BEGIN) begin
                base_addr <= addr;
                burst_count <= 2'h0;
                active <= 1'b1;
                first_after_desel <= !active;
            end else if (next_op == `SBSC_OP_DESEL || next_op == `SBSC_OP_SLEEP) begin
                active <= 1'b0;
            end else if (next_op == `SBSC_OP_NEXT && active) begin
                burst_count <= burst_count + 2'h1;
                first_after_desel <= 1'b0;
            end else if (active) begin
                first_after_desel <= 1'b0;
            end
            read_valid <= do_access && !next_wr;
            if (do_access && !next_wr) begin
                data_out <= mem_rdata;
            end
        end
    end

    // Registered read drive qualifier, gated later by enable pin
    reg drive_ok;
    always @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            drive_ok <= 1'b0;
        end else begin
            drive_ok <= do_access && !next_wr && !(next_op == `SBSC_OP_BEGIN && !active);
        end
    end

    // Enable pin gates drivers without a clock; writes and sleep mask it
    always @* begin
        data_oe = {LANES*LANE_W{1'b0}};
        if (drive_ok && read_valid && !output_drive_en_n && !sleep_request
            && !(do_write)) begin
            data_oe = {LANES*LANE_W{1'b1}};
        end
    end
endmodule // sbsc_cycle_decode
`default_nettype wire

// file: rtl/sbsc_defs.vh
// Constants for the synchronous burst SRAM cycle decoder.
// Assumes inclusion by bare name from every design file.
//
// Overview of operation
// - Deselect on disabled chip select with strobe
// - Sleep request forces power down, tri-state
// - Processor strobe with chip selected begins read burst
// - Controller strobe without write begins read
// - Controller strobe with write begins write
// - No strobe, step low, read: next address
// - No strobe, step low, write: next address
// - No strobe, step high, read: same address
// - No strobe, step high, write: same address
// - Write when global or gated lane low
// - Byte write updates selected lanes with parity
// - Output enable asynchronous, masked during writes
// - Read drives bus only when enabled, selected
// - No write in processor strobe cycle
// - Step low advances two-bit burst counter
// - Mode picks interleaved or linear order
// - Processor-started write completes on second clock
`ifndef SBSC_DEFS_VH
`define SBSC_DEFS_VH

// ----------------------------------------
// Cycle actions
// ----------------------------------------
`define SBSC_OP_W 3
`define SBSC_OP_IDLE 3'h0
`define SBSC_OP_DESEL 3'h1
`define SBSC_OP_SLEEP 3'h2
`define SBSC_OP_BEGIN 3'h3
`define SBSC_OP_NEXT 3'h4
`define SBSC_OP_HOLD 3'h5

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define SBSC_LANES 4
`define SBSC_LANE_W 9
`define SBSC_ADDR_W 8
`define SBSC_ORDER_INTERLEAVED 1'h1

`endif

// file: rtl/sbsc_burst_step.v
// Two-bit burst counter step function in a leaf module.
// Assumes mode is static while a burst runs.
`timescale 1ns/1ns
`default_nettype none
`include "sbsc_defs.vh"
module sbsc_burst_step (
    input wire [1:0] base,
    input wire [1:0] count,
    input wire mode,
    output wire [1:0] addr_low
);
    // Interleaved xors the count, linear adds it
    assign addr_low = mode ? (base ^ count) : (base + count);
endmodule // sbsc_burst_step
`default_nettype wire

// file: rtl/sbsc_lane_mem.v
// Byte-lane storage array with per-lane write strobes.
// Assumes one write per clock, combinational read.
`timescale 1ns/1ns
`default_nettype none
`include "sbsc_defs.vh"
module sbsc_lane_mem #(
    parameter ADDR_W = `SBSC_ADDR_W,
    parameter LANES = `SBSC_LANES,
    parameter LANE_W = `SBSC_LANE_W
) (
    input wire mclk,
    input wire [ADDR_W-1:0] addr,
    input wire [LANES-1:0] lane_we,
    input wire [LANES*LANE_W-1:0] wdata,
    output wire [LANES*LANE_W-1:0] rdata
);
    reg [LANES*LANE_W-1:0] store [0:(1<<ADDR_W)-1];
    integer i;
    always @(posedge mclk) begin
        for (i = 0; i < LANES; i = i + 1) begin
            if (lane_we[i]) begin
                store[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
            end
        end
    end
    assign rdata = store[addr];
endmodule // sbsc_lane_mem
`default_nettype wire

// file: test/sbsc_cycle_decode_sva.sv
// Checker for the burst SRAM cycle decoder.
// Assumes the decoder's own port names, bound by name below.
`timescale 1ns/1ns
`default_nettype none
`include "sbsc_defs.vh"
module sbsc_chk (
    input wire mclk,
    input wire rst_b,
    input wire select_pipelined_n,
    input wire depth_select_hi,
    input wire depth_select_lo_n,
    input wire sleep_request,
    input wire cpu_addr_strobe_n,
    input wire ctrl_addr_strobe_n,
    input wire burst_step_n,
    input wire global_write_n,
    input wire byte_write_gate_n,
    input wire [3:0] lane_write_sel_n,
    input wire output_drive_en_n,
    input wire [35:0] data_oe,
    input wire [2:0] cycle_op
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [1:0] up;
    always @(posedge mclk or negedge rst_b)
        if (!rst_b) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    wire on = up == 2'h3 && !sleep_request;
    wire sel = !select_pipelined_n && depth_select_hi && !depth_select_lo_n;
    wire wr = !global_write_n || (!byte_write_gate_n && !(&lane_write_sel_n));
    wire nos = ctrl_addr_strobe_n && (cpu_addr_strobe_n || select_pipelined_n);
    wire dsl = select_pipelined_n ? !ctrl_addr_strobe_n :
        (!(cpu_addr_strobe_n && ctrl_addr_strobe_n) && !sel);
    a_sleep_op: assert property (up == 2'h3 && sleep_request |=> cycle_op == `SBSC_OP_SLEEP)
        else $error("sleep not entered");
    a_sleep_tri: assert property (sleep_request |-> data_oe == '0)
        else $error("bus driven in sleep");
    a_desel_op: assert property (on && dsl |=> cycle_op == `SBSC_OP_DESEL)
        else $error("deselect missed");
    a_cpu_begin: assert property (on && sel && !cpu_addr_strobe_n |=> cycle_op == `SBSC_OP_BEGIN)
        else $error("processor start missed");
    a_ctrl_write: assert property (on && sel && cpu_addr_strobe_n && !ctrl_addr_strobe_n && wr
        |=> cycle_op == `SBSC_OP_BEGIN && data_oe == '0)
        else $error("write start wrong");
    a_next_op: assert property (on && nos && !burst_step_n
        |=> cycle_op inside {`SBSC_OP_NEXT, `SBSC_OP_IDLE})
        else $error("step not taken");
    a_hold_op: assert property (on && nos && burst_step_n
        |=> cycle_op inside {`SBSC_OP_HOLD, `SBSC_OP_IDLE})
        else $error("hold not taken");
    a_oe_off: assert property (output_drive_en_n |-> data_oe == '0)
        else $error("bus driven while disabled");
    a_first_tri: assert property (cycle_op == `SBSC_OP_DESEL ##1 cycle_op == `SBSC_OP_BEGIN
        |-> data_oe == '0)
        else $error("first cycle driven");
    c_burst: cover property (cycle_op == `SBSC_OP_BEGIN ##1 cycle_op == `SBSC_OP_NEXT);
    c_sleep: cover property (cycle_op == `SBSC_OP_SLEEP);
    c_first: cover property (cycle_op == `SBSC_OP_DESEL ##1 cycle_op == `SBSC_OP_BEGIN);
endmodule // sbsc_chk
bind sbsc_cycle_decode sbsc_chk chk (.*);
`default_nettype wire

// file: test/sbsc_host.sv
// Model of the controller on the shared data bus.
// Assumes the bench raises wr for write cycles only.
`timescale 1ns/1ns
`default_nettype none
module sbsc_host (
    input wire mclk,
    input wire wr,
    input wire rd_en,
    input wire [35:0] wdata,
    output logic [35:0] data_in,
    output logic output_drive_en_n
);
    logic [35:0] last = '0;
    always @(posedge mclk) if (wr) last <= wdata;
    // Released bus shows the inverse of the last value
    assign data_in = wr ? wdata : ~last;
    assign output_drive_en_n = wr | !rd_en;
endmodule // sbsc_host
`default_nettype wire

// file: test/tb_sbsc_cycle_decode.sv
// Self-checking bench for the burst SRAM cycle decoder.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "sbsc_defs.vh"
module tb_sbsc_cycle_decode;
    logic mclk = 0, rst_b = 0, sleep_request = 0, mode = 1, wr = 0, rd_en = 1;
    logic [7:0] c = 8'h5F, addr = 0;
    logic [3:0] lane_write_sel_n = 4'hF;
    logic [35:0] wd = 0, data_in, data_out, data_oe, m40;
    logic [2:0] cycle_op;
    logic powered_down, output_drive_en_n;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    wire select_pipelined_n, depth_select_hi, depth_select_lo_n, cpu_addr_strobe_n;
    wire ctrl_addr_strobe_n, burst_step_n, global_write_n, byte_write_gate_n;
    assign {select_pipelined_n, depth_select_hi, depth_select_lo_n, cpu_addr_strobe_n,
        ctrl_addr_strobe_n, burst_step_n, global_write_n, byte_write_gate_n} = c;
    sbsc_cycle_decode uut (.*);
    sbsc_host host (.mclk, .wr, .rd_en, .wdata(wd), .data_in, .output_drive_en_n);
    initial forever #50 mclk = ~mclk;
    task op(input [7:0] cc, input [7:0] aa, input [35:0] d, input w);
        @(posedge mclk);
        c <= cc; addr <= aa; wd <= d; wr <= w;
    endtask
    task chk(input [35:0] got, input [35:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd(input [7:0] aa, input [35:0] exp);
        op(8'h57, aa, 0, 0);
        op(8'h5F, 0, 0, 0);
        @(posedge mclk) #1 chk(data_out, exp);
    endtask
    task t_rw;
        m40 = 36'h123456789;
        op(8'h55, 8'h40, m40, 1);
        rd(8'h40, m40);
        chk(data_oe, '1);
        op(8'h56, 8'h40, 36'hFEDCBA987, 1);
        lane_write_sel_n <= 4'hD;
        m40 = (m40 & ~36'h3FE00) | (36'hFEDCBA987 & 36'h3FE00);
        op(8'h5F, 0, 0, 0);
        lane_write_sel_n <= 4'hF;
        rd(8'h40, m40);
        $display("t_rw done");
    endtask
    task t_burst(input m);
        logic [7:0] b;
        b = m ? 8'h21 : 8'h11;
        mode <= m;
        op(8'h55, b, 36'hA0, 1);
        for (int k = 1; k < 4; k++) op(8'h59, 0, 36'hA0 + k, 1);
        for (int k = 0; k < 4; k++)
            rd({b[7:2], m ? b[1:0] ^ k[1:0] : b[1:0] + k[1:0]}, 36'hA0 + k);
        $display("t_burst done");
    endtask
    task t_cpu;
        op(8'h4D, 8'h40, 0, 0);
        op(8'h5F, 0, 0, 0);
        #1 chk(cycle_op, `SBSC_OP_BEGIN);
        @(posedge mclk) #1 chk(data_out, m40);
        op(8'h4D, 8'h44, 0, 0);
        op(8'h5D, 0, 36'h00000BEEF, 1);
        op(8'h5F, 0, 0, 0);
        rd(8'h44, 36'h00000BEEF);
        $display("t_cpu done");
    endtask
    task t_desel;
        op(8'hD7, 0, 0, 0);
        op(8'h57, 8'h40, 0, 0);
        #1 chk(cycle_op, `SBSC_OP_DESEL);
        chk(powered_down, 1'b1);
        op(8'h5F, 0, 0, 0);
        #1 chk(data_oe, '0);
        rd(8'h40, m40);
        chk(data_oe, '1);
        chk(powered_down, 1'b0);
        rd_en <= 0;
        #1 chk(data_oe, '0);
        rd_en <= 1;
        #1 chk(data_oe, '1);
        sleep_request <= 1;
        #1 chk(data_oe, '0);
        repeat (2) @(posedge mclk);
        #1 chk(cycle_op, `SBSC_OP_SLEEP);
        $display("t_desel done");
    endtask
    task conclude;
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            conclude;
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_b <= 1;
        repeat (3) @(posedge mclk);
        t_rw;
        t_burst(0);
        t_burst(1);
        t_cpu;
        t_desel;
        conclude;
    end
endmodule // tb_sbsc_cycle_decode
`default_nettype wire
